// File: design/lane_steer_pkg.sv
// shared constants for big-endian read lane steering
package lane_steer_pkg;
	// external bus width codes
	localparam logic [1:0] BUS_W8 = 2'h0;
	localparam logic [1:0] BUS_W16 = 2'h1;
	localparam logic [1:0] BUS_W32 = 2'h2;
	// system transfer size codes
	localparam logic [2:0] SIZE_BYTE = 3'h0;
	localparam logic [2:0] SIZE_HALF = 3'h1;
	localparam logic [2:0] SIZE_WORD = 3'h2;
	// strobe patterns, a zero bit enables a lane
	localparam logic [3:0] STB_NONE = 4'hf;
	localparam logic [3:0] STB_ALL = 4'h0;
	localparam logic [3:0] STB_LANE0 = 4'he;
	localparam logic [3:0] STB_LOW_HALF = 4'hc;
	localparam logic [3:0] STB_HIGH_HALF = 4'h3;
	localparam logic [1:0] STB16_BOTH = 2'h0;
	localparam logic [1:0] STB16_LOW = 2'h2;
	localparam logic [1:0] STB16_HIGH = 2'h1;
	// transfer start addresses and counts
	localparam logic [1:0] ADDR_TOP = 2'h3;
	localparam logic [1:0] ADDR_ZERO = 2'h0;
	localparam logic [2:0] CNT_ONE = 3'h1;
	localparam logic [2:0] CNT_TWO = 3'h2;
	localparam logic [2:0] CNT_FOUR = 3'h4;
	localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
	typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_DONE} state_t;
endpackage

// File: design/lane_strobe_decode.sv
// byte-lane strobe pattern for one external transfer
module lane_strobe_decode
	import lane_steer_pkg::*;
(
	input wire logic [1:0] bus_width,
	input wire logic [2:0] size,
	input wire logic [1:0] sys_addr,
	input wire logic [1:0] ext_addr,
	input wire logic write,
	output logic [3:0] strobe_n
);
	// pick the active-low lane pattern from width, size and offset
	always_comb begin
		strobe_n = STB_NONE;
		case (bus_width)
			BUS_W8: strobe_n = STB_LANE0;
			BUS_W16: begin
				if (size == SIZE_BYTE) begin
					strobe_n = {2'h3, ext_addr[0] == sys_addr[1] && sys_addr[0] ? STB16_LOW : STB16_HIGH};
				end else begin
					strobe_n = {2'h3, STB16_BOTH};
				end
			end
			BUS_W32: begin
				if (size == SIZE_WORD) begin
					strobe_n = STB_ALL;
				end else if (size == SIZE_HALF) begin
					strobe_n = sys_addr[1] ? STB_LOW_HALF : STB_HIGH_HALF;
				end else if (write) begin
					strobe_n = ~(4'h1 << sys_addr);
				end else begin
					strobe_n = ~(4'h1 << ~sys_addr);
				end
			end
			default: strobe_n = STB_NONE;
		endcase
	end
endmodule

// File: design/big_endian_read_lane_steering.sv
// big-endian read lane steering and transfer splitting for static memory
// ==========================================
// What this block does
// - 8-bit bus word read: four transfers at 11,10,01,00, strobe 0.
// - 8-bit bus: byte from bits 7:0 lands on lane picked by address.
// - 8-bit bus halfword: 11 then 10 when bit 1 set, else 01 then 00.
// - 16-bit bus word: two transfers strobes 00, address 1 low half, 0 high.
// - 16-bit bus halfword: one transfer, address bit 1 picks low or high half.
// - 16-bit bus byte: address, strobe and lane follow the byte offset.
// - 32-bit bus word: all strobes on, lanes pass straight through.
// - 32-bit bus halfword: 1- gives 1100 low half, 0- gives 0011 high half.
// - 32-bit bus byte: one strobe low, lane 3 minus offset.
// - 32-bit little-endian byte write offset 00: strobes 1110, bits 7:0 out.
module big_endian_read_lane_steering
	import lane_steer_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic req_big_endian,
	input wire logic [2:0] req_size,
	input wire logic [1:0] req_addr,
	input wire logic [31:0] req_wdata,
	input wire logic [1:0] bus_width,
	input wire logic ext_ack,
	input wire logic [31:0] ext_rdata,
	output logic req_ready,
	output logic ext_req,
	output logic ext_write,
	output logic [1:0] ext_low_address,
	output logic [3:0] byte_lane_strobe_n,
	output logic [31:0] ext_wdata,
	output logic [31:0] rd_data,
	output logic rd_valid,
	output logic resp_error
);
	// ==========================================
	// helpers
	function automatic logic [31:0] expand(input logic [3:0] m);
		logic [31:0] r;
		r = DATA_ZERO;
		for (int i = 0; i < 4; i++) begin
			r[i*8 +: 8] = {8{m[i]}};
		end
		return r;
	endfunction

	// lanes of the system word that one external transfer fills
	function automatic logic [3:0] lane_mask(input logic [1:0] w, input logic [1:0] a, input logic [3:0] s);
		logic [3:0] m;
		m = 4'h0;
		case (w)
			BUS_W8: m = 4'h1 << ~a;
			BUS_W16: m = a[0] ? {2'h0, ~s[1:0]} : {~s[1:0], 2'h0};
			BUS_W32: m = ~s;
			default: m = 4'h0;
		endcase
		return m;
	endfunction

	// ==========================================
	// state
	state_t state_q, state_d;
	logic [2:0] size_q, size_d;
	logic [1:0] addr_q, addr_d;
	logic [1:0] width_q, width_d;
	logic write_q, write_d;
	logic [2:0] left_q, left_d;
	logic [31:0] acc_q, acc_d;
	logic ready_q, ready_d;
	logic ext_req_q, ext_req_d;
	logic [1:0] ext_addr_q, ext_addr_d;
	logic [3:0] strobe_q, strobe_d;
	logic [31:0] wdata_q, wdata_d;
	logic valid_q, valid_d;
	logic err_q, err_d;
	logic ext_write_q, ext_write_d;
	logic [1:0] issue_addr;
	logic [2:0] issue_size;
	logic [1:0] issue_sys;
	logic [1:0] issue_width;
	logic issue_write;
	logic [3:0] issue_strobe;
	logic [3:0] got_mask;

	lane_strobe_decode u_strobe (
		.bus_width(issue_width),
		.size(issue_size),
		.sys_addr(issue_sys),
		.ext_addr(issue_addr),
		.write(issue_write),
		.strobe_n(issue_strobe)
	);

	assign got_mask = lane_mask(width_q, ext_addr_q, strobe_q);

	// ==========================================
	// next-state logic
	always_comb begin
		state_d = state_q;
		size_d = size_q;
		addr_d = addr_q;
		width_d = width_q;
		write_d = write_q;
		left_d = left_q;
		acc_d = acc_q;
		ready_d = ready_q;
		ext_req_d = ext_req_q;
		ext_addr_d = ext_addr_q;
		strobe_d = strobe_q;
		wdata_d = wdata_q;
		valid_d = 1'b0;
		err_d = err_q;
		issue_addr = ext_addr_q - 2'h1;
		issue_size = size_q;
		issue_sys = addr_q;
		issue_width = width_q;
		issue_write = write_q;
		case (state_q)
			ST_IDLE: begin
				issue_size = req_size;
				issue_sys = req_addr;
				issue_width = bus_width;
				issue_write = req_write;
				issue_addr = ADDR_ZERO;
				left_d = CNT_ONE;
				// start address and transfer count per width and size
				case (bus_width)
					BUS_W8: begin
						if (req_size == SIZE_WORD) begin
							issue_addr = ADDR_TOP;
							left_d = CNT_FOUR;
						end else if (req_size == SIZE_HALF) begin
							issue_addr = {req_addr[1], 1'b1};
							left_d = CNT_TWO;
						end else begin
							issue_addr = req_addr;
						end
					end
					BUS_W16: begin
						if (req_size == SIZE_WORD) begin
							issue_addr = {1'b0, 1'b1};
							left_d = CNT_TWO;
						end else begin
							issue_addr = {1'b0, req_addr[1]};
						end
					end
					default: issue_addr = ADDR_ZERO;
				endcase
				if (req_valid && ready_q) begin
					size_d = req_size;
					addr_d = req_addr;
					width_d = bus_width;
					write_d = req_write;
					acc_d = DATA_ZERO;
					ready_d = 1'b0;
					// only big-endian reads and the 32-bit little-endian byte write are steered
					if (req_size > SIZE_WORD || bus_width > BUS_W32
						|| (req_write ? (req_big_endian || bus_width != BUS_W32 || req_size != SIZE_BYTE)
						: !req_big_endian)) begin
						err_d = 1'b1;
						state_d = ST_DONE;
					end else begin
						err_d = 1'b0;
						ext_req_d = 1'b1;
						ext_addr_d = issue_addr;
						strobe_d = issue_strobe;
						wdata_d = req_wdata;
						state_d = ST_XFER;
					end
				end
			end
			ST_XFER: begin
				if (ext_ack) begin
					acc_d = (acc_q & ~expand(got_mask)) | (ext_rdata & expand(got_mask));
					if (width_q == BUS_W8) begin
						acc_d = (acc_q & ~expand(got_mask)) | ({4{ext_rdata[7:0]}} & expand(got_mask));
					end else if (width_q == BUS_W16) begin
						acc_d = (acc_q & ~expand(got_mask)) | ({2{ext_rdata[15:0]}} & expand(got_mask));
					end
					left_d = left_q - CNT_ONE;
					if (left_q == CNT_ONE) begin
						ext_req_d = 1'b0;
						strobe_d = STB_NONE;
						state_d = ST_DONE;
					end else begin
						ext_addr_d = issue_addr;
						strobe_d = issue_strobe;
					end
				end
			end
			ST_DONE: begin
				valid_d = 1'b1;
				ready_d = 1'b1;
				state_d = ST_IDLE;
			end
			default: state_d = ST_IDLE;
		endcase
		ext_write_d = write_d && ext_req_d; // write flag registered so the pin comes from a flop
	end

	// ==========================================
	// registers
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_q <= ST_IDLE;
			size_q <= SIZE_BYTE;
			addr_q <= ADDR_ZERO;
			width_q <= BUS_W8;
			write_q <= 1'b0;
			left_q <= CNT_ONE;
			acc_q <= DATA_ZERO;
			ready_q <= 1'b1;
			ext_req_q <= 1'b0;
			ext_addr_q <= ADDR_ZERO;
			strobe_q <= STB_NONE;
			wdata_q <= DATA_ZERO;
			valid_q <= 1'b0;
			err_q <= 1'b0;
			ext_write_q <= 1'b0;
		end else begin
			state_q <= state_d;
			size_q <= size_d;
			addr_q <= addr_d;
			width_q <= width_d;
			write_q <= write_d;
			left_q <= left_d;
			acc_q <= acc_d;
			ready_q <= ready_d;
			ext_req_q <= ext_req_d;
			ext_addr_q <= ext_addr_d;
			strobe_q <= strobe_d;
			wdata_q <= wdata_d;
			valid_q <= valid_d;
			err_q <= err_d;
			ext_write_q <= ext_write_d;
		end
	end

	// outputs straight from flops
	assign req_ready = ready_q;
	assign ext_req = ext_req_q;
	assign ext_write = ext_write_q;
	assign ext_low_address = ext_addr_q;
	assign byte_lane_strobe_n = strobe_q;
	assign ext_wdata = wdata_q;
	assign rd_data = acc_q;
	assign rd_valid = valid_q;
	assign resp_error = err_q;
endmodule

// File: testbench/lane_steer_chk.sv
// assertion checker for big-endian read lane steering
module lane_steer_chk
	import lane_steer_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [2:0] req_size,
	input wire logic [1:0] req_addr,
	input wire logic [31:0] req_wdata,
	input wire logic [1:0] bus_width,
	input wire logic ext_ack,
	input wire logic ext_req,
	input wire logic ext_write,
	input wire logic [1:0] ext_low_address,
	input wire logic [3:0] byte_lane_strobe_n,
	input wire logic [31:0] ext_wdata,
	input wire logic rd_valid,
	input wire logic resp_error
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	// =====
	// external strobe, address, write data and response checks
	idle_strobe_a: assert property (!ext_req |-> byte_lane_strobe_n == STB_NONE)
		else $error("strobes active while idle");
	w8_start_a: assert property ($rose(ext_req) && bus_width == BUS_W8 |-> ext_low_address ==
		(req_size == SIZE_WORD ? ADDR_TOP : req_size == SIZE_HALF ? {req_addr[1], 1'b1} : req_addr))
		else $error("wrong first byte address");
	w8_step_a: assert property (ext_req && ext_ack && bus_width == BUS_W8 |=>
		!ext_req || ext_low_address == $past(ext_low_address) - 2'h1) else $error("byte address not stepping down");
	w8_lane_a: assert property (ext_req && bus_width == BUS_W8 |-> byte_lane_strobe_n == STB_LANE0)
		else $error("byte bus strobe wrong");
	w16_byte_a: assert property (ext_req && bus_width == BUS_W16 && req_size == SIZE_BYTE |->
		byte_lane_strobe_n == {2'h3, req_addr[0] ? STB16_LOW : STB16_HIGH} && ext_low_address == {1'b0, req_addr[1]})
		else $error("halfword bus byte mapping wrong");
	w16_wide_a: assert property (ext_req && bus_width == BUS_W16 && req_size != SIZE_BYTE |->
		byte_lane_strobe_n == STB_LOW_HALF && (req_size == SIZE_WORD || ext_low_address == {1'b0, req_addr[1]}))
		else $error("halfword bus wide mapping wrong");
	w32_strobe_a: assert property (ext_req && bus_width == BUS_W32 && !ext_write |->
		byte_lane_strobe_n == (req_size == SIZE_WORD ? STB_ALL : req_size == SIZE_HALF
		? (req_addr[1] ? STB_LOW_HALF : STB_HIGH_HALF) : ~(4'h1 << (2'h3 - req_addr))))
		else $error("word bus strobes wrong");
	le_write_a: assert property (ext_write |-> byte_lane_strobe_n == STB_LANE0
		&& ext_wdata[7:0] == req_wdata[7:0]) else $error("byte write lane wrong");
	finish_a: assert property ($fell(ext_req) |=> rd_valid && !resp_error)
		else $error("no response after transfers");
endmodule
bind big_endian_read_lane_steering lane_steer_chk chk (.clk_sys(clk_sys), .reset(reset), .req_size(req_size),
	.req_addr(req_addr), .req_wdata(req_wdata), .bus_width(bus_width), .ext_ack(ext_ack), .ext_req(ext_req),
	.ext_write(ext_write), .ext_low_address(ext_low_address), .byte_lane_strobe_n(byte_lane_strobe_n),
	.ext_wdata(ext_wdata), .rd_valid(rd_valid), .resp_error(resp_error));

// File: testbench/ext_mem_model.sv
// static memory model answering split transfers
module ext_mem_model
	import lane_steer_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic ext_req,
	input wire logic [1:0] ext_low_address,
	input wire logic [1:0] bus_width,
	input wire logic [31:0] word,
	input wire logic [1:0] dly,
	output logic ext_ack,
	output logic [31:0] ext_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] wait_q;
	// wait dly cycles then pulse one acknowledge
	always_ff @(posedge clk_sys) begin
		ext_ack <= 1'b0;
		wait_q <= 2'h0;
		if (!reset && ext_req && !ext_ack) begin
			if (wait_q == dly)
				ext_ack <= 1'b1;
			else
				wait_q <= wait_q + 2'h1;
		end
	end
	// big-endian bytes of word; unused lines show inverted junk
	always_comb begin
		ext_rdata = ~word;
		if (ext_ack && bus_width == BUS_W8)
			ext_rdata[7:0] = word[8 * (3 - ext_low_address) +: 8];
		if (ext_ack && bus_width == BUS_W16)
			ext_rdata[15:0] = word[16 * (1 - ext_low_address[0]) +: 16];
		if (ext_ack && bus_width == BUS_W32)
			ext_rdata = word;
	end
endmodule

// File: testbench/big_endian_read_lane_steering_tb.sv
// self-checking bench for big-endian read lane steering
module big_endian_read_lane_steering_tb import lane_steer_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys, reset, req_valid, req_write, req_big_endian, ext_ack, req_ready, ext_req, ext_write, rd_valid;
	logic resp_error;
	logic [2:0] req_size;
	logic [1:0] req_addr, bus_width, ext_low_address, dly;
	logic [3:0] byte_lane_strobe_n;
	logic [31:0] req_wdata, ext_rdata, ext_wdata, rd_data, word, rng;
	logic [33:0] note;
	logic [33:0] notes[$];
	int errors, samples_checked;
	big_endian_read_lane_steering dut (.clk_sys(clk_sys), .reset(reset), .req_valid(req_valid),
		.req_write(req_write), .req_big_endian(req_big_endian), .req_size(req_size), .req_addr(req_addr),
		.req_wdata(req_wdata), .bus_width(bus_width), .ext_ack(ext_ack), .ext_rdata(ext_rdata),
		.req_ready(req_ready), .ext_req(ext_req), .ext_write(ext_write), .ext_low_address(ext_low_address),
		.byte_lane_strobe_n(byte_lane_strobe_n), .ext_wdata(ext_wdata), .rd_data(rd_data),
		.rd_valid(rd_valid), .resp_error(resp_error));
	ext_mem_model mem (.clk_sys(clk_sys), .reset(reset), .ext_req(ext_req), .ext_low_address(ext_low_address),
		.bus_width(bus_width), .word(word), .dly(dly), .ext_ack(ext_ack), .ext_rdata(ext_rdata));
	// =====
	// helpers
	function automatic logic [31:0] next_rand();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	task automatic check(logic [31:0] seen, logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic wait_ready();
		int n;
		n = 0;
		while (req_ready !== 1'b1 && n < 40) begin
			@(negedge clk_sys);
			n++;
		end
		if (req_ready !== 1'b1) begin
			errors++;
			close_out();
		end
	endtask
	// present one request and note its expected answer
	task automatic send(logic wr, logic be, logic [2:0] sz, logic [1:0] a, logic [1:0] w, logic err);
		logic [31:0] m;
		wait_ready();
		m = sz == SIZE_WORD ? 32'hffff_ffff : sz == SIZE_HALF ? (a[1] ? 32'h0000_ffff : 32'hffff_0000)
			: 32'h0000_00ff << (8 * (3 - a));
		word = next_rand();
		dly = 2'(next_rand());
		{req_write, req_big_endian, req_size, req_addr, bus_width} = {wr, be, sz, a, w};
		req_wdata = next_rand();
		req_valid = 1'b1;
		notes.push_back({err, !(err || wr), word & m});
		@(negedge clk_sys);
		req_valid = 1'b0;
	endtask
	// =====
	// clock and response watcher
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	// responses are looked at mid-cycle, where the registered outputs have settled
	always @(negedge clk_sys) begin
		if (rd_valid === 1'b1) begin
			if (notes.size() == 0)
				check(32'h1, 32'h0);
			else begin
				note = notes.pop_front();
				check({31'h0, resp_error}, {31'h0, note[33]});
				if (note[32])
					check(rd_data, note[31:0]);
			end
		end
	end
	// =====
	// main sequence
	initial begin
		int n;
		rng = 32'h0000_3483;
		errors = 0;
		samples_checked = 0;
		{req_valid, req_write, req_big_endian, req_size, req_addr, bus_width, req_wdata, word, dly} = '0;
		reset = 1'b1;
		repeat (5) @(negedge clk_sys);
		reset = 1'b0;
		for (int w = 0; w < 3; w++)
			for (int s = 0; s < 3; s++)
				for (int a = 0; a < 4; a++)
					send(1'b0, 1'b1, 3'(s), 2'(a), 2'(w), 1'b0);
		$display("test mapping sweep done");
		send(1'b1, 1'b0, SIZE_BYTE, 2'h0, BUS_W32, 1'b0);
		send(1'b0, 1'b0, SIZE_WORD, 2'h0, BUS_W32, 1'b1);
		send(1'b0, 1'b1, 3'h3, 2'h0, BUS_W8, 1'b1);
		send(1'b0, 1'b1, SIZE_WORD, 2'h0, 2'h3, 1'b1);
		send(1'b1, 1'b1, SIZE_BYTE, 2'h0, BUS_W32, 1'b1);
		n = 0;
		while (notes.size() != 0 && n < 100) begin
			@(negedge clk_sys);
			n++;
		end
		if (notes.size() != 0)
			errors++;
		$display("test write and refusal done");
		close_out();
	end
endmodule
